// ===== design/lbr_bridge_ctrl.sv
// Functional notes
// - with display forwarding on, memory accesses from 000A0000h to 000BFFFFh are claimed and sent downstream.
// - display I/O needs address bits 31:16 zero and bits 9:0 in 3B0h-3BBh or 3C0h-3DFh, bits 15:10 ignored unless full decode is on.
// - with display forwarding on, the same display addresses are never forwarded upstream.
// - display forwarding ignores the alias filter and all base/limit windows.
// - display I/O needs the I/O space enable, display memory needs the memory space enable.
// - with display forwarding off (reset), display addresses go downstream only through the windows.
// - the alias filter acts only on I/O addresses inside the I/O window and below 10000h.
// - with the alias filter on, downstream I/O to the top 768 bytes of each 1 KB block is refused.
// - with the alias filter on, upstream I/O to the top 768 bytes of each 1 KB block is forwarded.
// - with the alias filter off (reset), all I/O inside the I/O window goes downstream; the code forwards it only while the I/O space enable is set.
// - a secondary system error is forwarded only when both error enables are set.
// - the secondary error forward control resets to zero and then suppresses all such events.
// - with full decode and display forwarding on, I/O bits 15:10 must also be zero.
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ns
module lbr_bridge_ctrl (
	input  wire logic        clk,
	input  wire logic        reset,
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic             hreadyout,
	output logic [31:0]      hrdata,
	output logic             hresp,
	input  wire logic        reqValid,
	input  wire logic [31:0] reqAddr,
	input  wire logic        reqIsIo,
	input  wire logic        reqUpstream,
	output logic             rspValid,
	output logic             rspForward,
	output logic             rspDisplay,
	output logic             rspBlocked,
	input  wire logic        secSerrN,
	output logic             priSerrEvent
);

	// software-visible state
	logic [15:0] bridgeCtrl_r;
	logic [15:0] command_r;
	logic [31:0] ioBase_r;
	logic [31:0] ioLimit_r;
	logic [31:0] memBase_r;
	logic [31:0] memLimit_r;
	logic [31:0] pfBase_r;
	logic [31:0] pfLimit_r;

	// bus slave state
	logic        wrPend_r;
	logic [7:0]  wrAddr_r;
	logic [31:0] hrdata_r;
	logic [31:0] readMux;
	logic        addrAccept;
	logic        readBypass;

	// decode results
	logic        rspValid_r;
	logic        rspForward_r;
	logic        rspDisplay_r;
	logic        rspBlocked_r;
	logic [15:0] fwdCount_r;
	logic [15:0] blockCount_r;
	logic        fwdNxt;
	logic        dispNxt;
	logic        blockNxt;

	// control bits decoded from the registers
	logic        displayFwdEn;
	logic        aliasFiltEn;
	logic        fullDecode;
	logic        ioSpaceEn;
	logic        memSpaceEn;

	lbr_serr_if serrBus ();

	// true when addr sits in an enabled inclusive window
	function automatic logic inWindow(input logic [31:0] addr, input logic [31:0] base, input logic [31:0] limit);
		inWindow = (base <= limit) && (addr >= base) && (addr <= limit);
	endfunction

	// legacy display memory range
	function automatic logic isDisplayMem(input logic [31:0] addr);
		isDisplayMem = (addr >= lbr_pkg::DISP_MEM_LO) && (addr <= lbr_pkg::DISP_MEM_HI);
	endfunction

	// legacy display I/O, aliases included unless full decode
	function automatic logic isDisplayIo(input logic [31:0] addr, input logic full);
		logic lowHit;
		logic aliasOk;
		lowHit = ((addr[9:0] >= lbr_pkg::DISP_IO1_LO) && (addr[9:0] <= lbr_pkg::DISP_IO1_HI)) ||
			((addr[9:0] >= lbr_pkg::DISP_IO2_LO) && (addr[9:0] <= lbr_pkg::DISP_IO2_HI));
		aliasOk = !full || (addr[15:10] == 6'h00);
		isDisplayIo = (addr[31:16] == 16'h0000) && lowHit && aliasOk;
	endfunction

	// alias area: inside the I/O window, first 64 KB, top 768 bytes of a 1 KB block
	function automatic logic isAliasArea(input logic [31:0] addr, input logic inIo);
		isAliasArea = inIo && (addr[31:16] == 16'h0000) && (addr[9:8] != 2'h0);
	endfunction

	// tallies stick at all ones rather than wrap back to a small count
	function automatic logic [15:0] satInc16(input logic [15:0] value);
		satInc16 = (value == 16'hFFFF) ? value : value + 16'h0001;
	endfunction

	// registers that a write can change; status and tallies are read-only
	function automatic logic isWritable(input logic [7:0] addr);
		case (addr)
			lbr_pkg::OFS_BRIDGE_CTRL: isWritable = 1'b1;
			lbr_pkg::OFS_COMMAND:     isWritable = 1'b1;
			lbr_pkg::OFS_IO_BASE:     isWritable = 1'b1;
			lbr_pkg::OFS_IO_LIMIT:    isWritable = 1'b1;
			lbr_pkg::OFS_MEM_BASE:    isWritable = 1'b1;
			lbr_pkg::OFS_MEM_LIMIT:   isWritable = 1'b1;
			lbr_pkg::OFS_PF_BASE:     isWritable = 1'b1;
			lbr_pkg::OFS_PF_LIMIT:    isWritable = 1'b1;
			default:                  isWritable = 1'b0;
		endcase
	endfunction

	// value a pending write leaves behind, read-only bits cleared
	function automatic logic [31:0] writeImage(input logic [7:0] addr, input logic [31:0] data);
		case (addr)
			lbr_pkg::OFS_BRIDGE_CTRL: writeImage = {16'h0000, data[15:0] & lbr_pkg::CTRL_WMASK};
			lbr_pkg::OFS_COMMAND:     writeImage = {16'h0000, data[15:0] & lbr_pkg::CMD_WMASK};
			default:                  writeImage = data;
		endcase
	endfunction

	assign displayFwdEn = bridgeCtrl_r[lbr_pkg::BIT_DISPLAY_FWD];
	assign aliasFiltEn  = bridgeCtrl_r[lbr_pkg::BIT_ALIAS_FILT];
	assign fullDecode   = bridgeCtrl_r[lbr_pkg::BIT_FULL_DECODE];
	assign ioSpaceEn    = command_r[lbr_pkg::BIT_IO_SPACE];
	assign memSpaceEn   = command_r[lbr_pkg::BIT_MEM_SPACE];

	// error forwarding enables go to the forwarder
	assign serrBus.forwardEn = bridgeCtrl_r[lbr_pkg::BIT_SYSERR_FWD];
	assign serrBus.syserrEn  = command_r[lbr_pkg::BIT_PRI_SYSERR];

	lbr_serr_fwd uSerrFwd (
		.clk      (clk),
		.reset    (reset),
		.secSerrN (secSerrN),
		.bus      (serrBus.fwd)
	);

	// zero wait states, always OKAY
	assign hreadyout  = 1'b1;
	assign hresp      = 1'b0;
	assign addrAccept = hsel && hready && (htrans == lbr_pkg::HTRANS_NONSEQ || htrans == 2'h3);

	// address phase is held until the data phase that writes
	always_ff @(posedge clk) begin
		if (reset) begin
			wrPend_r <= 1'b0;
			wrAddr_r <= 8'h00;
		end else begin
			wrPend_r <= addrAccept && hwrite;
			if (addrAccept) begin
				wrAddr_r <= haddr[7:0];
			end
		end
	end

	// control writes land at the end of the data phase; only writable bits stick
	always_ff @(posedge clk) begin
		if (reset) begin
			bridgeCtrl_r <= lbr_pkg::CTRL_RESET;
			command_r    <= lbr_pkg::CMD_RESET;
		end else if (wrPend_r) begin
			case (wrAddr_r)
				lbr_pkg::OFS_BRIDGE_CTRL: begin
					bridgeCtrl_r <= hwdata[15:0] & lbr_pkg::CTRL_WMASK;
				end
				lbr_pkg::OFS_COMMAND: begin
					command_r <= hwdata[15:0] & lbr_pkg::CMD_WMASK;
				end
				default: begin
				end
			endcase
		end
	end

	// I/O window; empty after reset so nothing is forwarded by accident
	always_ff @(posedge clk) begin
		if (reset) begin
			ioBase_r  <= lbr_pkg::BASE_RESET;
			ioLimit_r <= lbr_pkg::LIMIT_RESET;
		end else if (wrPend_r) begin
			case (wrAddr_r)
				lbr_pkg::OFS_IO_BASE: begin
					ioBase_r <= hwdata;
				end
				lbr_pkg::OFS_IO_LIMIT: begin
					ioLimit_r <= hwdata;
				end
				default: begin
				end
			endcase
		end
	end

	// memory and prefetchable windows; unmapped writes vanish
	always_ff @(posedge clk) begin
		if (reset) begin
			memBase_r  <= lbr_pkg::BASE_RESET;
			memLimit_r <= lbr_pkg::LIMIT_RESET;
			pfBase_r   <= lbr_pkg::BASE_RESET;
			pfLimit_r  <= lbr_pkg::LIMIT_RESET;
		end else if (wrPend_r) begin
			case (wrAddr_r)
				lbr_pkg::OFS_MEM_BASE: begin
					memBase_r <= hwdata;
				end
				lbr_pkg::OFS_MEM_LIMIT: begin
					memLimit_r <= hwdata;
				end
				lbr_pkg::OFS_PF_BASE: begin
					pfBase_r <= hwdata;
				end
				lbr_pkg::OFS_PF_LIMIT: begin
					pfLimit_r <= hwdata;
				end
				default: begin
				end
			endcase
		end
	end

	// read multiplexer; unmapped reads return zero
	always_comb begin
		readMux = 32'h00000000;
		case (haddr[7:0])
			lbr_pkg::OFS_BRIDGE_CTRL: readMux = {16'h0000, bridgeCtrl_r};
			lbr_pkg::OFS_COMMAND:     readMux = {16'h0000, command_r};
			lbr_pkg::OFS_IO_BASE:     readMux = ioBase_r;
			lbr_pkg::OFS_IO_LIMIT:    readMux = ioLimit_r;
			lbr_pkg::OFS_MEM_BASE:    readMux = memBase_r;
			lbr_pkg::OFS_MEM_LIMIT:   readMux = memLimit_r;
			lbr_pkg::OFS_PF_BASE:     readMux = pfBase_r;
			lbr_pkg::OFS_PF_LIMIT:    readMux = pfLimit_r;
			lbr_pkg::OFS_STATUS: begin
				readMux[lbr_pkg::STAT_FWD_POS]         = rspForward_r;
				readMux[lbr_pkg::STAT_DISP_POS]        = rspDisplay_r;
				readMux[lbr_pkg::STAT_BLOCK_POS]       = rspBlocked_r;
				readMux[lbr_pkg::STAT_SERR_POS +: 8]   = serrBus.eventCount;
			end
			lbr_pkg::OFS_COUNTS:      readMux = {blockCount_r, fwdCount_r};
			default:                  readMux = 32'h00000000;
		endcase
	end

	// a read pipelined behind a write to the same register must not return the stale value
	assign readBypass = wrPend_r && (wrAddr_r == haddr[7:0]) && isWritable(wrAddr_r);

	// read data captured at the end of the address phase so it stands in the data phase
	always_ff @(posedge clk) begin
		if (reset) begin
			hrdata_r <= 32'h00000000;
		end else if (addrAccept && !hwrite) begin
			hrdata_r <= readBypass ? writeImage(wrAddr_r, hwdata) : readMux;
		end
	end

	assign hrdata = hrdata_r;

	// forwarding decision for one decoded transaction
	always_comb begin
		logic inIo;
		logic inMem;
		logic aliasHit;
		logic dispHit;
		inIo     = 1'b0;
		inMem    = 1'b0;
		aliasHit = 1'b0;
		dispHit  = 1'b0;
		fwdNxt   = 1'b0;
		dispNxt  = 1'b0;
		blockNxt = 1'b0;
		inIo  = inWindow(reqAddr, ioBase_r, ioLimit_r);
		inMem = inWindow(reqAddr, memBase_r, memLimit_r) || inWindow(reqAddr, pfBase_r, pfLimit_r);
		aliasHit = aliasFiltEn && isAliasArea(reqAddr, inIo);
		if (reqIsIo) begin
			dispHit = displayFwdEn && isDisplayIo(reqAddr, fullDecode);
		end else begin
			dispHit = displayFwdEn && isDisplayMem(reqAddr);
		end
		dispNxt = dispHit;
		if (!reqUpstream) begin
			if (dispHit) begin
				// windows and the alias filter play no part here
				fwdNxt = reqIsIo ? ioSpaceEn : memSpaceEn;
			end else if (reqIsIo) begin
				fwdNxt   = ioSpaceEn && inIo && !aliasHit;
				blockNxt = inIo && aliasHit;
			end else begin
				fwdNxt = memSpaceEn && inMem;
			end
		end else begin
			if (dispHit) begin
				blockNxt = 1'b1;
			end else if (reqIsIo) begin
				// outside the window goes up, plus the alias area when filtering
				fwdNxt = !inIo || aliasHit;
			end else begin
				fwdNxt = !inMem;
			end
		end
	end

	// decision is frozen when taken, so later writes cannot disturb it
	always_ff @(posedge clk) begin
		if (reset) begin
			rspValid_r   <= 1'b0;
			rspForward_r <= 1'b0;
			rspDisplay_r <= 1'b0;
			rspBlocked_r <= 1'b0;
		end else begin
			rspValid_r <= reqValid;
			if (reqValid) begin
				rspForward_r <= fwdNxt;
				rspDisplay_r <= dispNxt;
				rspBlocked_r <= blockNxt;
			end
		end
	end

	// saturating tallies of decisions, for software diagnosis
	always_ff @(posedge clk) begin
		if (reset) begin
			fwdCount_r   <= 16'h0000;
			blockCount_r <= 16'h0000;
		end else if (reqValid) begin
			if (fwdNxt) begin
				fwdCount_r <= satInc16(fwdCount_r);
			end
			if (blockNxt) begin
				blockCount_r <= satInc16(blockCount_r);
			end
		end
	end

	assign rspValid     = rspValid_r;
	assign rspForward   = rspForward_r;
	assign rspDisplay   = rspDisplay_r;
	assign rspBlocked   = rspBlocked_r;
	assign priSerrEvent = serrBus.eventPulse;

endmodule

// ===== design/lbr_pkg.sv
package lbr_pkg;

	// register byte addresses on the bus
	localparam logic [7:0] OFS_BRIDGE_CTRL = 8'h00;
	localparam logic [7:0] OFS_COMMAND     = 8'h04;
	localparam logic [7:0] OFS_IO_BASE     = 8'h08;
	localparam logic [7:0] OFS_IO_LIMIT    = 8'h0C;
	localparam logic [7:0] OFS_MEM_BASE    = 8'h10;
	localparam logic [7:0] OFS_MEM_LIMIT   = 8'h14;
	localparam logic [7:0] OFS_PF_BASE     = 8'h18;
	localparam logic [7:0] OFS_PF_LIMIT    = 8'h1C;
	localparam logic [7:0] OFS_STATUS      = 8'h20;
	localparam logic [7:0] OFS_COUNTS      = 8'h24;

	// secondary bridge control fields
	localparam int BIT_SYSERR_FWD  = 1;
	localparam int BIT_ALIAS_FILT  = 2;
	localparam int BIT_DISPLAY_FWD = 3;
	localparam int BIT_FULL_DECODE = 4;
	localparam logic [15:0] CTRL_WMASK = 16'h001E;
	localparam logic [15:0] CTRL_RESET = 16'h0000;

	// command register fields
	localparam int BIT_IO_SPACE   = 0;
	localparam int BIT_MEM_SPACE  = 1;
	localparam int BIT_PRI_SYSERR = 8;
	localparam logic [15:0] CMD_WMASK = 16'h0103;
	localparam logic [15:0] CMD_RESET = 16'h0000;

	// windows reset empty: base above limit
	localparam logic [31:0] BASE_RESET  = 32'hFFFFFFFF;
	localparam logic [31:0] LIMIT_RESET = 32'h00000000;

	// legacy display ranges
	localparam logic [31:0] DISP_MEM_LO = 32'h000A0000;
	localparam logic [31:0] DISP_MEM_HI = 32'h000BFFFF;
	localparam logic [9:0]  DISP_IO1_LO = 10'h3B0;
	localparam logic [9:0]  DISP_IO1_HI = 10'h3BB;
	localparam logic [9:0]  DISP_IO2_LO = 10'h3C0;
	localparam logic [9:0]  DISP_IO2_HI = 10'h3DF;

	// status register fields
	localparam int STAT_FWD_POS   = 0;
	localparam int STAT_DISP_POS  = 1;
	localparam int STAT_BLOCK_POS = 2;
	localparam int STAT_SERR_POS  = 8;

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

endpackage

// ===== design/lbr_serr_fwd.sv
`timescale 1ns/1ns
module lbr_serr_fwd (
	input  wire logic  clk,
	input  wire logic  reset,
	input  wire logic  secSerrN,
	lbr_serr_if.fwd    bus
);

	logic       serrSeen_r;
	logic       eventPulse_r;
	logic [7:0] eventCount_r;
	logic       serrRise;

	// one event per assertion, so a long low level is not counted twice
	assign serrRise = ~secSerrN & ~serrSeen_r;

	// history of the secondary error line
	always_ff @(posedge clk) begin
		if (reset) begin
			serrSeen_r <= 1'b0;
		end else begin
			serrSeen_r <= ~secSerrN;
		end
	end

	// forward only with both enables set
	always_ff @(posedge clk) begin
		if (reset) begin
			eventPulse_r <= 1'b0;
		end else begin
			eventPulse_r <= serrRise & bus.forwardEn & bus.syserrEn;
		end
	end

	// saturating tally of forwarded events
	always_ff @(posedge clk) begin
		if (reset) begin
			eventCount_r <= 8'h00;
		end else if (eventPulse_r && eventCount_r != 8'hFF) begin
			eventCount_r <= eventCount_r + 8'h01;
		end
	end

	assign bus.eventPulse = eventPulse_r;
	assign bus.eventCount = eventCount_r;

endmodule

// ===== design/lbr_serr_if.sv
`timescale 1ns/1ns
interface lbr_serr_if;
	logic       forwardEn;
	logic       syserrEn;
	logic       eventPulse;
	logic [7:0] eventCount;

	modport ctrl (output forwardEn, output syserrEn, input eventPulse, input eventCount);
	modport fwd  (input forwardEn, input syserrEn, output eventPulse, output eventCount);
endinterface

// ===== testbench/lbr_bridge_ctrl_chk.sv
`timescale 1ns/1ns
module lbr_bridge_ctrl_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic reqValid,
	input wire logic reqUpstream,
	input wire logic rspValid,
	input wire logic rspForward,
	input wire logic rspDisplay,
	input wire logic rspBlocked,
	input wire logic secSerrN,
	input wire logic priSerrEvent
);
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	// zero-wait slave that never answers with an error
	a_bus_ready: assert property (hreadyout && !hresp) else $error("bus slave stalled or errored");
	// each request cycle owes exactly one answer cycle
	a_rsp_follows: assert property (reqValid |=> rspValid) else $error("decode answer missing");
	a_rsp_cause: assert property (rspValid |-> $past(reqValid)) else $error("decode answer unprompted");
	a_rsp_exclusive: assert property (rspValid |-> !(rspForward && rspBlocked))
		else $error("forward and block together");
	// display hits are refused upstream, never refused downstream
	a_up_display: assert property (rspValid && rspDisplay && $past(reqUpstream) |-> rspBlocked && !rspForward)
		else $error("display address went upstream");
	a_down_display: assert property (rspValid && rspDisplay && !$past(reqUpstream) |-> !rspBlocked)
		else $error("display address blocked downstream");
	// forwarded error needs an asserted line one edge before
	a_serr_cause: assert property (priSerrEvent |-> !$past(secSerrN)) else $error("error event unprompted");
	a_serr_pulse: assert property (priSerrEvent |=> !priSerrEvent) else $error("error event too long");
	c_blocked: cover property (rspValid && rspBlocked);
	c_display: cover property (rspValid && rspDisplay);
	c_serr: cover property (priSerrEvent);
endmodule
bind lbr_bridge_ctrl lbr_bridge_ctrl_chk i_lbr_bridge_ctrl_chk (.clk(clk), .reset(reset), .hreadyout(hreadyout),
	.hresp(hresp), .reqValid(reqValid), .reqUpstream(reqUpstream), .rspValid(rspValid), .rspForward(rspForward),
	.rspDisplay(rspDisplay), .rspBlocked(rspBlocked), .secSerrN(secSerrN), .priSerrEvent(priSerrEvent));

// ===== testbench/lbr_sec_agent.sv
`timescale 1ns/1ns
module lbr_sec_agent (
	input  wire logic clk,
	input  wire logic raise,
	output logic      secSerrN
);
	logic [1:0] holdCnt_r = 2'h0;
	// hold the line low three cycles: a long assertion must still give one event
	always_ff @(posedge clk) begin
		if (raise) begin
			holdCnt_r <= 2'h3;
		end else if (holdCnt_r != 2'h0) begin
			holdCnt_r <= holdCnt_r - 2'h1;
		end
	end
	// pull-up brings the line high once released
	assign secSerrN = (holdCnt_r == 2'h0);
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ns
module tb_top;
	logic        clk = 1'h0, reset = 1'h1, hsel = 1'h0, hwrite = 1'h0, raise = 1'h0;
	logic        reqValid = 1'h0, reqIsIo = 1'h0, reqUpstream = 1'h0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, reqAddr = 32'h0, hrdata, rd;
	logic        hreadyout, hresp, rspValid, rspForward, rspDisplay, rspBlocked, secSerrN, priSerrEvent;
	int          n_fail = 0, comparisons = 0, nEvt = 0, ev0;

	always #20 clk = ~clk;
	// count forwarded error pulses
	always @(posedge clk) if (priSerrEvent === 1'h1) nEvt++;

	lbr_bridge_ctrl i_lbr_bridge_ctrl (.clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
		.hresp(hresp), .reqValid(reqValid), .reqAddr(reqAddr), .reqIsIo(reqIsIo), .reqUpstream(reqUpstream),
		.rspValid(rspValid), .rspForward(rspForward), .rspDisplay(rspDisplay), .rspBlocked(rspBlocked),
		.secSerrN(secSerrN), .priSerrEvent(priSerrEvent));
	lbr_sec_agent i_lbr_sec_agent (.clk(clk), .raise(raise), .secSerrN(secSerrN));

	task automatic tally_and_finish;
		$display("comparisons %0d n_fail %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// single word transfer; address phase held until ready is sampled
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'h1;
		htrans <= lbr_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= wr;
		do @(posedge clk); while (hreadyout !== 1'h1);
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'h1);
		rd = hrdata;
	endtask

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk("register", e, rd);
	endtask

	// e = {forward, display, blocked}
	task automatic dec(input logic [31:0] a, input logic io, input logic up, input logic [2:0] e);
		reqValid <= 1'h1;
		reqAddr <= a;
		reqIsIo <= io;
		reqUpstream <= up;
		@(posedge clk);
		reqValid <= 1'h0;
		@(posedge clk);
		chk("decode", {28'h0, 1'h1, e}, {28'h0, rspValid, rspForward, rspDisplay, rspBlocked});
	endtask

	task automatic serr(input logic [31:0] n);
		ev0 = nEvt;
		raise <= 1'h1;
		@(posedge clk);
		raise <= 1'h0;
		repeat (8) @(posedge clk);
		chk("error events", n, nEvt - ev0);
	endtask

	// generous: the sequence needs about 140 cycles
	initial begin
		repeat (5000) @(posedge clk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge clk);
		reset <= 1'h0;
		@(posedge clk);
		rdchk(8'h00, 32'h0);
		rdchk(8'h08, 32'hFFFFFFFF);
		rdchk(8'h30, 32'h0);
		bus(1'h1, 8'h00, 32'hFFFFFFFF);
		rdchk(8'h00, 32'h1E);
		bus(1'h1, 8'h04, 32'hFFFF);
		rdchk(8'h04, 32'h103);
		bus(1'h1, 8'h00, 32'h0);
		dec(32'hA0000, 1'h0, 1'h0, 3'h0);
		bus(1'h1, 8'h00, 32'h8);
		dec(32'hA0000, 1'h0, 1'h0, 3'h6);
		dec(32'hBFFFF, 1'h0, 1'h0, 3'h6);
		dec(32'hC0000, 1'h0, 1'h0, 3'h0);
		dec(32'h9FFFF, 1'h0, 1'h0, 3'h0);
		dec(32'h3B0, 1'h1, 1'h0, 3'h6);
		dec(32'h3BB, 1'h1, 1'h0, 3'h6);
		dec(32'h3BC, 1'h1, 1'h0, 3'h0);
		dec(32'h3DF, 1'h1, 1'h0, 3'h6);
		dec(32'h3E0, 1'h1, 1'h0, 3'h0);
		dec(32'h7BB, 1'h1, 1'h0, 3'h6);
		dec(32'h103B0, 1'h1, 1'h0, 3'h0);
		dec(32'hA0000, 1'h0, 1'h1, 3'h3);
		dec(32'h3C0, 1'h1, 1'h1, 3'h3);
		bus(1'h1, 8'h04, 32'h102);
		dec(32'h3C0, 1'h1, 1'h0, 3'h2);
		bus(1'h1, 8'h04, 32'h101);
		dec(32'hA0000, 1'h0, 1'h0, 3'h2);
		bus(1'h1, 8'h04, 32'h103);
		bus(1'h1, 8'h00, 32'h18);
		dec(32'h7C0, 1'h1, 1'h0, 3'h0);
		dec(32'h3C0, 1'h1, 1'h0, 3'h6);
		bus(1'h1, 8'h08, 32'h1000);
		bus(1'h1, 8'h0C, 32'h1FFF);
		bus(1'h1, 8'h00, 32'h4);
		dec(32'h1000, 1'h1, 1'h0, 3'h4);
		dec(32'h1100, 1'h1, 1'h0, 3'h1);
		dec(32'h1100, 1'h1, 1'h1, 3'h4);
		dec(32'h1000, 1'h1, 1'h1, 3'h0);
		dec(32'h2100, 1'h1, 1'h0, 3'h0);
		bus(1'h1, 8'h00, 32'h0);
		dec(32'h1100, 1'h1, 1'h0, 3'h4);
		bus(1'h1, 8'h00, 32'hC);
		dec(32'h13C0, 1'h1, 1'h0, 3'h6);
		dec(32'h3C0, 1'h1, 1'h0, 3'h6);
		bus(1'h1, 8'h00, 32'h0);
		serr(32'h0);
		bus(1'h1, 8'h00, 32'h2);
		serr(32'h1);
		bus(1'h1, 8'h04, 32'h3);
		serr(32'h0);
		rdchk(8'h20, 32'h103);
		rdchk(8'h24, 32'h0003000C);
		tally_and_finish();
	end
endmodule
